// File: logic/tcc_timer.sv
// 16-bit timer/counter with input capture, noise canceler and 8-bit bus slave
`timescale 1ns/10ps
// How it works
// - count takes two byte locations; high location goes to the shared holding byte
// - low read copies count high to holding; low write loads high from holding
// - clock select zero stops counting; count stays readable and writable
// - a bus write of the count beats clear, increment and decrement
// - on each timer enable count clears, rises or falls; top and zero flagged
// - waveform mode field is split over control a and control b
// - overflow flag set at the mode point and may request an interrupt
// - matching edge on chosen capture input stores full count in capture register
// - capture flag sets in the same cycle the capture register is loaded
// - capture flag requests interrupt when enabled; cleared when serviced
// - writing one clears the capture flag; writing zero leaves it
// - capture low read copies capture high to holding; high read returns holding
// - capture register writable only in modes using it as top; high then low
// - comparator capture select swaps capture pin for comparator output
// - inputs synchronised like the count pin; canceler adds four cycles
// - capture input disabled only in modes with capture register as top
// - canceler output changes only after four equal samples
// - canceler enabled in control b, runs on system clock, ignores prescaler
// - every new capture overwrites the capture register
// - holding byte keeps its value across low byte writes
module tcc_timer
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tcc_bus_t bus,
   output logic [7:0] rdata,
   input wire logic timer_clock_enable,
   input wire logic capture_pin,
   input wire logic comparator_output,
   input wire logic irq_ack_ovf,
   input wire logic irq_ack_cap,
   output logic irq_ovf,
   output logic irq_cap,
   output logic [15:0] count_value,
   output logic at_top,
   output logic at_bottom
);
   // ==========================================
   // control registers
   logic [7:0] timer_control_a_q;
   logic [7:0] timer_control_b_q;
   logic [7:0] comparator_control_status_q;
   logic [7:0] mask_q;
   logic [7:0] hold_q;
   logic [15:0] count_q;
   logic [15:0] capture_q;
   logic up_q;
   logic ovf_flag_q;
   logic cap_flag_q;
   logic [3:0] waveform_mode_field;
   logic [2:0] clock_select_field;
   logic icr_top;
   logic [15:0] top_value;

   // mode field is split between the two control registers
   assign waveform_mode_field = {timer_control_b_q[TCC_B_WGM_HI +: 2],
                                 timer_control_a_q[TCC_A_WGM_LO +: 2]};
   assign clock_select_field = timer_control_b_q[TCC_B_CS_LO +: 3];

   // modes 8, 10, 12 and 14 take their top from the capture register
   function automatic logic uses_icr_top(input logic [3:0] m);
      uses_icr_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
   endfunction

   function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] icr);
      case (m)
         4'h1, 4'h5: mode_top = 16'h00FF;
         4'h2, 4'h6: mode_top = 16'h01FF;
         4'h3, 4'h7: mode_top = 16'h03FF;
         4'h8, 4'hA, 4'hC, 4'hE: mode_top = icr;
         default: mode_top = TCC_MAX;
      endcase
   endfunction

   assign icr_top = uses_icr_top(waveform_mode_field);
   assign top_value = mode_top(waveform_mode_field, capture_q);

   // dual slope modes count up then down
   function automatic logic dual_slope(input logic [3:0] m);
      dual_slope = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
   endfunction

   // clear on top modes
   function automatic logic ctc_mode(input logic [3:0] m);
      ctc_mode = (m == 4'h4) || (m == 4'hC);
   endfunction

   logic wr_cnt_lo;
   logic rd_cnt_lo;
   logic wr_cap_lo;
   logic rd_cap_lo;
   logic tick;
   assign wr_cnt_lo = bus.wr && (bus.addr == TCC_ADDR_CNT_LO);
   assign rd_cnt_lo = bus.rd && (bus.addr == TCC_ADDR_CNT_LO);
   assign wr_cap_lo = bus.wr && (bus.addr == TCC_ADDR_CAP_LO);
   assign rd_cap_lo = bus.rd && (bus.addr == TCC_ADDR_CAP_LO);
   // no clock source selected means no counting at all
   assign tick = timer_clock_enable && (clock_select_field != 3'h0);

   // ==========================================
   // plain control registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_a_q <= TCC_RST_BYTE;
         timer_control_b_q <= TCC_RST_BYTE;
         comparator_control_status_q <= TCC_RST_BYTE;
         mask_q <= TCC_RST_BYTE;
      end else if (bus.wr) begin
         case (bus.addr)
            TCC_ADDR_CTRL_A: timer_control_a_q <= bus.wdata;
            TCC_ADDR_CTRL_B: timer_control_b_q <= bus.wdata;
            TCC_ADDR_CMP_CTRL: comparator_control_status_q <= bus.wdata;
            TCC_ADDR_MASK: mask_q <= bus.wdata;
            default: ;
         endcase
      end
   end

   // ==========================================
   // shared holding byte; kept until the next high write or low read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= TCC_RST_BYTE;
      end else if (bus.wr && (bus.addr == TCC_ADDR_CNT_HI || bus.addr == TCC_ADDR_CAP_HI)) begin
         hold_q <= bus.wdata;
      end else if (rd_cnt_lo) begin
         hold_q <= count_q[15:8];
      end else if (rd_cap_lo) begin
         hold_q <= capture_q[15:8];
      end
      // low writes leave the holding byte untouched so it can be reused
   end

   // ==========================================
   // counter unit
   logic at_top_w;
   logic at_bot_w;
   logic ovf_evt;
   assign at_top_w = (count_q == top_value);
   assign at_bot_w = (count_q == TCC_BOTTOM);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= TCC_RST_WORD;
         up_q <= 1'b1;
      end else if (wr_cnt_lo) begin
         count_q <= {hold_q, bus.wdata};
      end else if (tick) begin
         if (dual_slope(waveform_mode_field)) begin
            if (up_q && at_top_w) begin
               up_q <= 1'b0;
               count_q <= count_q - 16'h0001;
            end else if (!up_q && at_bot_w) begin
               up_q <= 1'b1;
               count_q <= count_q + 16'h0001;
            end else if (up_q) begin
               count_q <= count_q + 16'h0001;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end else if (at_top_w || count_q == TCC_MAX) begin
            count_q <= TCC_BOTTOM;
            up_q <= 1'b1;
         end else begin
            count_q <= count_q + 16'h0001;
            up_q <= 1'b1;
         end
      end
   end

   // overflow point: bottom in dual slope, max in normal/ctc, top in fast pwm
   always_comb begin
      if (!tick) begin
         ovf_evt = 1'b0;
      end else if (dual_slope(waveform_mode_field)) begin
         ovf_evt = !up_q && at_bot_w;
      end else if (ctc_mode(waveform_mode_field) || waveform_mode_field == 4'h0) begin
         ovf_evt = (count_q == TCC_MAX);
      end else begin
         ovf_evt = at_top_w;
      end
   end

   // ==========================================
   // capture input: sync, optional canceler, edge detect
   logic [1:0] pin_sync_q;
   logic [1:0] cmp_sync_q;
   logic sel_in;
   logic [TCC_NC_SAMPLES-2:0] nc_shift_q;
   logic nc_out_q;
   logic filt;
   logic filt_prev_q;
   logic cap_evt;

   // two stages each; only the second stage is read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_q <= 2'b00;
         cmp_sync_q <= 2'b00;
      end else begin
         pin_sync_q <= {pin_sync_q[0], capture_pin};
         cmp_sync_q <= {cmp_sync_q[0], comparator_output};
      end
   end

   // switching the source may itself look like an edge, software must clear the flag
   assign sel_in = comparator_control_status_q[TCC_CMPC_SEL] ? cmp_sync_q[1]
                                                             : pin_sync_q[1];

   // canceler runs on every system clock, never on the prescaled tick;
   // three stored samples plus the live one make four, so the output flop
   // is itself one of the four added cycles rather than a fifth
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nc_shift_q <= '0;
         nc_out_q <= 1'b0;
      end else begin
         nc_shift_q <= {nc_shift_q[TCC_NC_SAMPLES-3:0], sel_in};
         if (&{nc_shift_q, sel_in}) begin
            nc_out_q <= 1'b1;
         end else if (~|{nc_shift_q, sel_in}) begin
            nc_out_q <= 1'b0;
         end
      end
   end

   // canceler path costs four extra cycles of latency
   assign filt = timer_control_b_q[TCC_B_NC] ? nc_out_q : sel_in;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         filt_prev_q <= 1'b0;
      end else begin
         filt_prev_q <= filt;
      end
   end

   // detector is shut off while the capture register defines top
   assign cap_evt = !icr_top && (timer_control_b_q[TCC_B_EDGE] ? (filt && !filt_prev_q)
                                                              : (!filt && filt_prev_q));

   // ==========================================
   // capture register; a new event simply overwrites an unread value
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         capture_q <= TCC_RST_WORD;
      end else if (wr_cap_lo && icr_top) begin
         capture_q <= {hold_q, bus.wdata};
      end else if (cap_evt) begin
         capture_q <= count_q;
      end
   end

   // ==========================================
   // flags: hardware set wins over software or acknowledge clear
   logic clr_flags;
   assign clr_flags = bus.wr && (bus.addr == TCC_ADDR_FLAGS);

   // capture flag: a new capture in the acknowledge cycle keeps it set
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cap_flag_q <= 1'b0;
      end else if (cap_evt) begin
         cap_flag_q <= 1'b1;
      end else if (irq_ack_cap) begin
         cap_flag_q <= 1'b0;
      end else if (clr_flags && bus.wdata[TCC_FLAG_CAP]) begin
         cap_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ovf_flag_q <= 1'b0;
      end else if (ovf_evt && !wr_cnt_lo) begin
         ovf_flag_q <= 1'b1;
      end else if (irq_ack_ovf || (clr_flags && bus.wdata[TCC_FLAG_OVF])) begin
         ovf_flag_q <= 1'b0;
      end
   end

   // ==========================================
   // registered outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_ovf <= 1'b0;
         irq_cap <= 1'b0;
         count_value <= TCC_RST_WORD;
         at_top <= 1'b0;
         at_bottom <= 1'b0;
      end else begin
         irq_ovf <= ovf_flag_q && mask_q[TCC_FLAG_OVF] && !irq_ack_ovf;
         irq_cap <= cap_flag_q && mask_q[TCC_FLAG_CAP] && !irq_ack_cap;
         count_value <= count_q;
         at_top <= at_top_w;
         at_bottom <= at_bot_w;
      end
   end

   // ==========================================
   // read data, one cycle after the read strobe, zero otherwise
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= TCC_RST_BYTE;
      end else if (bus.rd) begin
         case (bus.addr)
            TCC_ADDR_CTRL_A: rdata <= timer_control_a_q;
            TCC_ADDR_CTRL_B: rdata <= timer_control_b_q;
            TCC_ADDR_CNT_LO: rdata <= count_q[7:0];
            TCC_ADDR_CNT_HI: rdata <= hold_q;
            TCC_ADDR_CAP_LO: rdata <= capture_q[7:0];
            TCC_ADDR_CAP_HI: rdata <= hold_q;
            TCC_ADDR_FLAGS: rdata <= {2'b00, cap_flag_q, 4'h0, ovf_flag_q};
            TCC_ADDR_MASK: rdata <= mask_q;
            TCC_ADDR_CMP_CTRL: rdata <= comparator_control_status_q;
            default: rdata <= TCC_RST_BYTE;
         endcase
      end else begin
         rdata <= TCC_RST_BYTE;
      end
   end
endmodule // tcc_timer

// File: common/tcc_pkg.sv
// package for the 16-bit timer/counter with input capture
package tcc_pkg;
   // ==========================================
   // register map, byte addresses on the 8-bit bus
   localparam logic [3:0] TCC_ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] TCC_ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] TCC_ADDR_CNT_LO = 4'h2;
   localparam logic [3:0] TCC_ADDR_CNT_HI = 4'h3;
   localparam logic [3:0] TCC_ADDR_CAP_LO = 4'h4;
   localparam logic [3:0] TCC_ADDR_CAP_HI = 4'h5;
   localparam logic [3:0] TCC_ADDR_FLAGS = 4'h6;
   localparam logic [3:0] TCC_ADDR_MASK = 4'h7;
   localparam logic [3:0] TCC_ADDR_CMP_CTRL = 4'h8;
   // ==========================================
   // field positions
   localparam int TCC_A_WGM_LO = 0;      // control a bits 1:0 -> mode bits 1:0
   localparam int TCC_B_CS_LO = 0;       // control b bits 2:0 clock select
   localparam int TCC_B_WGM_HI = 3;      // control b bits 4:3 -> mode bits 3:2
   localparam int TCC_B_EDGE = 6;        // 1 = rising edge capture
   localparam int TCC_B_NC = 7;          // noise canceler enable
   localparam int TCC_FLAG_OVF = 0;
   localparam int TCC_FLAG_CAP = 5;
   localparam int TCC_CMPC_SEL = 2;      // comparator capture select
   // ==========================================
   // reset values and counts
   localparam logic [7:0] TCC_RST_BYTE = 8'h00;
   localparam logic [15:0] TCC_RST_WORD = 16'h0000;
   localparam int TCC_NC_SAMPLES = 4;
   localparam logic [15:0] TCC_MAX = 16'hFFFF;
   localparam logic [15:0] TCC_BOTTOM = 16'h0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } tcc_bus_t;
endpackage

// File: tb/tcc_timer_asserts.sv
// checker bound to the timer/counter top
`timescale 1ns/10ps
module tcc_timer_chk
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tcc_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic timer_clock_enable,
   input wire logic capture_pin,
   input wire logic comparator_output,
   input wire logic irq_ack_ovf,
   input wire logic irq_ack_cap,
   input wire logic irq_ovf,
   input wire logic irq_cap,
   input wire logic [15:0] count_value,
   input wire logic at_top,
   input wire logic at_bottom
);
   logic [2:0] cs_q;
   logic [3:0] mode_q;
   logic cmask_q;
   logic [1:0] live_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // shadow of control bits, moves on the same edge as the block
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cs_q <= 3'h0;
         mode_q <= 4'h0;
         cmask_q <= 1'b0;
      end else if (bus.wr) begin
         case (bus.addr)
            TCC_ADDR_CTRL_A: mode_q[1:0] <= bus.wdata[1:0];
            TCC_ADDR_CTRL_B: begin
               cs_q <= bus.wdata[2:0];
               mode_q[3:2] <= bus.wdata[4:3];
            end
            TCC_ADDR_MASK: cmask_q <= bus.wdata[TCC_FLAG_CAP];
            default: ;
         endcase
      end
   end
   // registered outputs agree with each other only from the first edge after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         live_q <= 2'b00;
      end else begin
         live_q <= {live_q[0], 1'b1};
      end
   end
   // ==========================================
   // assertions; count_value lags the counter by one edge
   rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   cnt_write_a: assert property ((bus.wr && bus.addr == TCC_ADDR_CNT_LO && $past(bus.wr)
      && $past(bus.addr) == TCC_ADDR_CNT_HI) |-> ##2
      count_value == {$past(bus.wdata, 3), $past(bus.wdata, 2)}) else $error("count write lost");
   cnt_stop_a: assert property ((cs_q == 3'h0 && !bus.wr) |=> ##1 $stable(count_value))
      else $error("count moved while stopped");
   cnt_up_a: assert property ((mode_q == 4'h0 && cs_q != 3'h0 && timer_clock_enable
      && !bus.wr) |=> ##1 count_value == $past(count_value) + 16'h0001)
      else $error("count did not step up");
   bottom_flag_a: assert property (live_q[0] |-> at_bottom == (count_value == TCC_BOTTOM))
      else $error("bottom flag wrong");
   cnt_lo_rd_a: assert property ((bus.rd && bus.addr == TCC_ADDR_CNT_LO)
      |=> rdata == count_value[7:0]) else $error("count low read wrong");
   cnt_hi_rd_a: assert property ((bus.rd && bus.addr == TCC_ADDR_CNT_LO) ##1
      (bus.rd && bus.addr == TCC_ADDR_CNT_HI) |=> rdata == $past(count_value[15:8]))
      else $error("count high read not from holding byte");
   irq_mask_a: assert property (irq_cap |-> cmask_q || $past(cmask_q))
      else $error("capture irq while masked");
   irq_ack_a: assert property (irq_ack_cap |=> ##1 !irq_cap)
      else $error("capture irq kept after service");
   flag_keep_a: assert property ((irq_cap && bus.wr && bus.addr == TCC_ADDR_FLAGS
      && !bus.wdata[TCC_FLAG_CAP] && !irq_ack_cap && !$past(irq_ack_cap) && !$past(bus.wr))
      |=> irq_cap) else $error("zero write cleared capture flag");
   flag_clear_a: assert property ((bus.wr && bus.addr == TCC_ADDR_FLAGS
      && bus.wdata[TCC_FLAG_CAP]) |=> ##1 !irq_cap) else $error("capture flag not cleared");
   cap_irq_c: cover property ($rose(irq_cap));
   top_c: cover property (at_top);
   read_c: cover property (bus.rd ##1 rdata != 8'h00);
endmodule // tcc_timer_chk
bind tcc_timer tcc_timer_chk #(.CNT_W(CNT_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .bus(bus), .rdata(rdata), .timer_clock_enable(timer_clock_enable),
   .capture_pin(capture_pin), .comparator_output(comparator_output),
   .irq_ack_ovf(irq_ack_ovf), .irq_ack_cap(irq_ack_cap), .irq_ovf(irq_ovf),
   .irq_cap(irq_cap), .count_value(count_value), .at_top(at_top), .at_bottom(at_bottom));

// File: tb/tcc_cpu_model.sv
// cpu side model: byte bus master, interrupt service and capture sources
`timescale 1ns/10ps
module tcc_cpu_model
   import tcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] rdata,
   output tcc_bus_t bus,
   output logic capture_pin,
   output logic comparator_output,
   output logic irq_ack_ovf,
   output logic irq_ack_cap
);
   // ==========================================
   // bus cycles; released lines show the inverse, not the last value
   initial begin
      bus = '{1'b0, 1'b0, 4'h0, 8'h00};
      capture_pin = 1'b0;
      comparator_output = 1'b0;
      irq_ack_ovf = 1'b0;
      irq_ack_cap = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // high byte first, low byte on the very next edge
   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus <= '{1'b1, 1'b0, a + 4'h1, d[15:8]};
      @(posedge clk_sys);
      bus <= '{1'b1, 1'b0, a, d[7:0]};
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b0, ~a, ~d[7:0]};
   endtask
   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1 d = rdata;
   endtask
   // low byte first so the holding byte is loaded before the high read
   task automatic rd16(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b1, a + 4'h1, 8'h00};
      #1 d[7:0] = rdata;
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1 d[15:8] = rdata;
   endtask
   task automatic ack_cap();
      @(posedge clk_sys);
      irq_ack_cap <= 1'b1;
      @(posedge clk_sys);
      irq_ack_cap <= 1'b0;
   endtask
   // sel 1 drives the comparator line, 0 the capture pin
   task automatic pin(input logic sel, input logic v);
      @(posedge clk_sys);
      if (sel) comparator_output <= v;
      else capture_pin <= v;
   endtask
endmodule // tcc_cpu_model

// File: tb/tb.sv
// self-checking bench for the timer/counter
`timescale 1ns/10ps
module tb
   import tcc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic tce = 1'b0;
   tcc_bus_t bus;
   logic [7:0] rdata, b;
   logic cap_pin, cmp_out, ack_ovf, ack_cap, irq_ovf, irq_cap, at_top, at_bottom;
   logic [15:0] count_value, v;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int n0, n1;
   always #5 clk_sys = ~clk_sys;
   tcc_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .timer_clock_enable(tce), .capture_pin(cap_pin), .comparator_output(cmp_out),
      .irq_ack_ovf(ack_ovf), .irq_ack_cap(ack_cap), .irq_ovf(irq_ovf), .irq_cap(irq_cap),
      .count_value(count_value), .at_top(at_top), .at_bottom(at_bottom));
   tcc_cpu_model cpu (.clk_sys(clk_sys), .rdata(rdata), .bus(bus), .capture_pin(cap_pin),
      .comparator_output(cmp_out), .irq_ack_ovf(ack_ovf), .irq_ack_cap(ack_cap));
   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         tce <= 1'b1;
         @(posedge clk_sys);
         tce <= 1'b0;
      end
   endtask
   // cycles from a rising capture pin to the capture interrupt
   task automatic lat(output int n);
      cpu.pin(1'b0, 1'b1);
      // let the launching edge settle before looking at the interrupt
      #1;
      n = 0;
      while (irq_cap !== 1'b1 && n < 40) begin
         idle(1);
         n++;
      end
   endtask
   // ==========================================
   // scenarios
   task automatic t_count();
      cpu.rd8(4'hF, b);
      chk("unmapped read", 16'h0000, {8'h00, b});
      cpu.wr16(TCC_ADDR_CNT_LO, 16'h01FF);
      ticks(3);
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("stopped count", 16'h01FF, v);
      cpu.wr(TCC_ADDR_CNT_HI, 8'hA5);
      cpu.wr(TCC_ADDR_CNT_LO, 8'h00);
      cpu.wr(TCC_ADDR_CNT_LO, 8'h34);
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("reused high byte", 16'hA534, v);
      cpu.wr(TCC_ADDR_CNT_HI, 8'h77);
      cpu.rd8(TCC_ADDR_CAP_LO, b);
      cpu.wr(TCC_ADDR_CNT_LO, 8'h00);
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("shared holding byte", 16'h0000, v);
   endtask
   task automatic t_run();
      cpu.wr(TCC_ADDR_CTRL_B, 8'h01);
      cpu.wr16(TCC_ADDR_CNT_LO, 16'hFFFE);
      ticks(3);
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("wrapped count", 16'h0001, v);
      cpu.rd8(TCC_ADDR_FLAGS, b);
      chk("overflow flag", 16'h0001, {8'h00, b});
      cpu.wr(TCC_ADDR_MASK, 8'h01);
      idle(2);
      chk("overflow irq", 16'h0001, {15'h0, irq_ovf});
      cpu.wr(TCC_ADDR_FLAGS, 8'h01);
      cpu.rd8(TCC_ADDR_FLAGS, b);
      chk("overflow cleared", 16'h0000, {8'h00, b});
      chk("overflow irq cleared", 16'h0000, {15'h0, irq_ovf});
      cpu.wr(TCC_ADDR_CNT_HI, 8'h00);
      fork
         cpu.wr(TCC_ADDR_CNT_LO, 8'h10);
         ticks(1);
      join
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("write beats tick", 16'h0010, v);
      cpu.wr(TCC_ADDR_CTRL_A, 8'h01);
      cpu.wr16(TCC_ADDR_CNT_LO, 16'h00FE);
      ticks(1);
      idle(2);
      chk("at top", 16'h0001, {15'h0, at_top});
      ticks(2);
      cpu.rd16(TCC_ADDR_CNT_LO, v);
      chk("dual slope count", 16'h00FD, v);
      cpu.wr(TCC_ADDR_CTRL_A, 8'h00);
   endtask
   task automatic t_capture();
      cpu.wr(TCC_ADDR_MASK, 8'h20);
      cpu.wr(TCC_ADDR_CTRL_B, 8'h40);
      cpu.wr16(TCC_ADDR_CNT_LO, 16'h1234);
      cpu.pin(1'b0, 1'b1);
      idle(8);
      chk("capture irq", 16'h0001, {15'h0, irq_cap});
      cpu.rd16(TCC_ADDR_CAP_LO, v);
      chk("captured count", 16'h1234, v);
      cpu.wr16(TCC_ADDR_CNT_LO, 16'h2222);
      cpu.pin(1'b0, 1'b0);
      idle(8);
      cpu.rd16(TCC_ADDR_CAP_LO, v);
      chk("falling ignored", 16'h1234, v);
      cpu.pin(1'b0, 1'b1);
      idle(8);
      cpu.rd16(TCC_ADDR_CAP_LO, v);
      chk("capture overwrite", 16'h2222, v);
      cpu.wr(TCC_ADDR_FLAGS, 8'h00);
      idle(3);
      chk("zero write keeps flag", 16'h0001, {15'h0, irq_cap});
      cpu.wr(TCC_ADDR_CTRL_B, 8'h00);
      cpu.wr(TCC_ADDR_FLAGS, 8'h20);
      idle(3);
      chk("one write clears flag", 16'h0000, {15'h0, irq_cap});
      cpu.pin(1'b0, 1'b0);
      idle(8);
      chk("falling capture", 16'h0001, {15'h0, irq_cap});
      cpu.ack_cap();
      idle(3);
      chk("serviced flag", 16'h0000, {15'h0, irq_cap});
   endtask
   task automatic t_filter();
      cpu.wr(TCC_ADDR_CTRL_B, 8'h40);
      lat(n0);
      cpu.pin(1'b0, 1'b0);
      cpu.wr(TCC_ADDR_CTRL_B, 8'hC0);
      idle(10);
      cpu.wr(TCC_ADDR_FLAGS, 8'h20);
      lat(n1);
      chk("canceler delay", 16'(n0 + 4), 16'(n1));
      cpu.pin(1'b0, 1'b0);
      idle(10);
      cpu.wr(TCC_ADDR_FLAGS, 8'h20);
      cpu.pin(1'b0, 1'b1);
      idle(2);
      cpu.pin(1'b0, 1'b0);
      idle(12);
      chk("short pulse rejected", 16'h0000, {15'h0, irq_cap});
   endtask
   task automatic t_source();
      cpu.wr(TCC_ADDR_CTRL_B, 8'h40);
      cpu.wr(TCC_ADDR_CMP_CTRL, 8'h04);
      cpu.wr(TCC_ADDR_FLAGS, 8'h20);
      cpu.pin(1'b0, 1'b1);
      idle(12);
      chk("pin ignored", 16'h0000, {15'h0, irq_cap});
      cpu.pin(1'b1, 1'b1);
      idle(8);
      chk("comparator capture", 16'h0001, {15'h0, irq_cap});
      cpu.wr16(TCC_ADDR_CAP_LO, 16'h5555);
      cpu.rd16(TCC_ADDR_CAP_LO, v);
      chk("capture write refused", 16'h2222, v);
      cpu.wr(TCC_ADDR_CMP_CTRL, 8'h00);
      cpu.wr(TCC_ADDR_CTRL_B, 8'h18);
      cpu.wr(TCC_ADDR_FLAGS, 8'h20);
      cpu.wr16(TCC_ADDR_CAP_LO, 16'h5555);
      cpu.rd16(TCC_ADDR_CAP_LO, v);
      chk("capture write as top", 16'h5555, v);
      cpu.pin(1'b0, 1'b0);
      idle(12);
      chk("detector off at top", 16'h0000, {15'h0, irq_cap});
   endtask
   // ==========================================
   // hang guard, then the main sequence
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_count();
      t_run();
      t_capture();
      t_filter();
      t_source();
      tally_and_finish();
   end
endmodule // tb
